// [status_service_regs.svh]
/*
  Constants for the status and service-request unit: status bit positions,
  reset values and command codes used by the command byte stream.
  Assumes it is included by bare name from files that need these values.
*/
`ifndef STATUS_SERVICE_REGS_SVH
`define STATUS_SERVICE_REGS_SVH

// Primary byte bit positions
`define PRI_PARAM_BIT 0
`define PRI_EXTCHG_BIT 2
`define PRI_SWEEP_BIT 4
`define PRI_SYNTAX_BIT 5
`define PRI_RQS_BIT 6
// Extended byte bit positions
`define EXT_SELFTEST_BIT 0
`define EXT_POWER_BIT 5
`define EXT_UNLEVEL_BIT 6
`define EXT_AIRFLOW_BIT 7
// Primary condition-bit mask and extended used-bit mask
`define PRI_COND_MASK 8'h35
`define EXT_USED_MASK 8'he1
// Bits that always read zero
`define PRI_UNUSED_MASK 8'h8a
`define EXT_UNUSED_MASK 8'h1e
// Reset values
`define STATUS_RESET 8'h00
`define MASK_RESET 8'h00
// Mask-load command code byte (arbitrary encoding of the two-letter code)
`define MASK_LOAD_CODE 8'h4d

`endif

// [status_service_pkg.sv]
/*
  Types shared by the status and service-request unit.
  Assumes nothing beyond a SystemVerilog tool.
*/
`default_nettype none
package status_service_pkg;
  // Command byte parser states
  typedef enum logic [0:0] {CMD_IDLE, CMD_MASK_BYTE} cmd_state_t;
endpackage
`default_nettype wire

// [level_sync.sv]
/*
  Two-flip-flop synchroniser for one pin-level input.
  Assumes ref_clk_i and asynchronous active-low reset.
*/
`default_nettype none
module level_sync
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Asynchronous level in, synchronised out
  input wire logic async_i,
  output logic sync_o
);
  logic meta_ff; // First stage, read only by second stage
  logic hold_ff; // Second stage

  // Shift the level through two stages
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_ff <= 1'b0;
      hold_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= async_i;
      hold_ff <= meta_ff;
    end
  end

  assign sync_o = hold_ff;
endmodule
`default_nettype wire

// [condition_latch.sv]
/*
  One sticky condition bit: set by a one-cycle event, cleared by device
  clear; a set in the clear cycle wins so no event is lost.
  Assumes events and clear are on ref_clk_i.
*/
`default_nettype none
module condition_latch
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Set and clear
  input wire logic set_i,
  input wire logic clr_i,
  // Latched state
  output logic flag_o
);
  logic flag_ff; // Sticky bit
  logic nxt_flag; // Next value

  // Set wins over clear
  assign nxt_flag = set_i | (flag_ff & ~clr_i);

  // Hold the flag
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      flag_ff <= 1'b0;
    else
      flag_ff <= nxt_flag;
  end

  assign flag_o = flag_ff;
endmodule
`default_nettype wire

// [status_service_request_unit.sv]
/*
  Status and service-request unit of a sweep oscillator on an instrument
  bus. Holds the primary and extended status bytes and the request mask,
  raises the service request line and honours device clear.
  Assumes the bus front end delivers received command bytes with a
  one-cycle strobe on ref_clk_i and a one-cycle device-clear pulse.
  Condition events from the
  instrument core are one-cycle pulses on ref_clk_i; extended conditions
  are raw levels from pins and are synchronised here.
  Limitation: the extended byte shows live pin state three clocks late,
  so a pin pulse shorter than a clock may never be seen; the change flag
  in the primary byte is the latched record of changes that were seen.
  The request mask survives device clear; only reset returns it to zero.
  A controller that wants a new mask after a clear must send it again.
*/
`default_nettype none
`include "status_service_regs.svh"
module status_service_request_unit
  import status_service_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Command byte stream from the bus front end
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_byte_i,
  input wire logic device_clear_i,
  // Condition events from the instrument core
  input wire logic param_altered_i,
  input wire logic syntax_error_i,
  input wire logic sweep_end_i,
  // Extended conditions from pins (levels)
  input wire logic airflow_fail_i,
  input wire logic rf_unleveled_i,
  input wire logic power_event_i,
  input wire logic selftest_fail_i,
  // Status outputs
  output logic [7:0] primary_service_status_o,
  output logic [7:0] extended_condition_status_o,
  output logic [7:0] request_mask_o,
  output logic service_request_o
);

  // Synchronised extended condition levels
  logic airflow_s;
  logic unlevel_s;
  logic power_s;
  logic selftest_s;

  // Latched primary conditions
  logic param_q;
  logic syntax_q;
  logic sweep_q;
  logic extchg_q;

  // Extended byte, mask, request flag and parser
  logic [7:0] ext_ff; // Extended byte, live state of used bits
  logic [7:0] nxt_ext;
  logic [7:0] mask_ff; // Loaded request mask
  logic [7:0] nxt_mask;
  logic rqs_ff; // Service requested flag
  logic nxt_rqs;
  cmd_state_t cmd_ff; // Parser state
  cmd_state_t nxt_cmd;

  // Decoded helpers
  wire [7:0] pri_cond; // Condition bits without the request flag
  wire ext_changed; // Any used extended bit differs
  wire mask_hit; // Masked condition present
  wire code_seen; // Mask-load code arrives
  wire mask_take; // Mask byte arrives

  // Pin synchronisers for the four extended conditions
  // One per pin: the pins are unrelated levels, so no word crosses domains
  level_sync u_sync_air
  (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(airflow_fail_i),
    .sync_o(airflow_s)
  );
  level_sync u_sync_lvl
  (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(rf_unleveled_i),
    .sync_o(unlevel_s)
  );
  level_sync u_sync_pwr
  (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(power_event_i),
    .sync_o(power_s)
  );
  level_sync u_sync_st
  (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(selftest_fail_i),
    .sync_o(selftest_s)
  );

  // Extended byte follows present condition of used bits; unused read zero
  always_comb
  begin
    nxt_ext = `STATUS_RESET;
    nxt_ext[`EXT_AIRFLOW_BIT] = airflow_s;
    nxt_ext[`EXT_UNLEVEL_BIT] = unlevel_s;
    nxt_ext[`EXT_POWER_BIT] = power_s;
    nxt_ext[`EXT_SELFTEST_BIT] = selftest_s;
  end

  // A change in any used extended bit is an event for primary bit 2
  // Comparing against the next value flags the change as the byte updates,
  // so the change bit and the new extended byte appear on the same edge
  assign ext_changed = |((nxt_ext ^ ext_ff) & `EXT_USED_MASK);

  // Sticky primary conditions; device clear rearms them
  // Separate latches keep each cause visible until the controller issues device clear
  condition_latch u_lat_param
  (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .set_i(param_altered_i),
    .clr_i(device_clear_i),
    .flag_o(param_q)
  );
  condition_latch u_lat_syntax
  (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .set_i(syntax_error_i),
    .clr_i(device_clear_i),
    .flag_o(syntax_q)
  );
  condition_latch u_lat_sweep
  (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .set_i(sweep_end_i),
    .clr_i(device_clear_i),
    .flag_o(sweep_q)
  );
  condition_latch u_lat_extchg
  (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .set_i(ext_changed),
    .clr_i(device_clear_i),
    .flag_o(extchg_q)
  );

  // Assemble condition bits at their weights; bits 7, 3, 1 read zero
  assign pri_cond = {2'h0, syntax_q, sweep_q, 1'b0, extchg_q, 1'b0, param_q};

  // Only masked conditions may request service; the rest are only recorded
  assign mask_hit = |(pri_cond & mask_ff & `PRI_COND_MASK);

  // Request flag: set by a masked condition, cleared only by device clear.
  // A hit in the clear cycle is judged on the old latches, which clear too,
  // so the flag drops; a fresh event then re-latches and re-raises it.
  assign nxt_rqs = device_clear_i ? 1'b0 : (rqs_ff | mask_hit);

  // Parser: mask-load code, then exactly one binary mask byte. A byte that
  // meets device clear is dropped; the controller sends code and byte again,
  // which is cheaper than trusting half a load.
  assign code_seen = cmd_valid_i && (cmd_ff == CMD_IDLE) && (cmd_byte_i == `MASK_LOAD_CODE);
  assign mask_take = cmd_valid_i && (cmd_ff == CMD_MASK_BYTE) && !device_clear_i;
  assign nxt_mask = mask_take ? cmd_byte_i : mask_ff;

  // Next parser state; device clear abandons a half-received load
  // so a stray byte after the clear cannot be taken as a mask
  always_comb
  begin
    nxt_cmd = cmd_ff;
    case (cmd_ff)
      CMD_IDLE:
        if (code_seen)
          nxt_cmd = CMD_MASK_BYTE;
      CMD_MASK_BYTE:
        if (cmd_valid_i)
          nxt_cmd = CMD_IDLE;
      default:
        nxt_cmd = CMD_IDLE;
    endcase
    if (device_clear_i)
      nxt_cmd = CMD_IDLE;
  end

  // State registers; the mask and extended byte survive device clear, the request flag and parser state clear
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ext_ff <= `STATUS_RESET;
      mask_ff <= `MASK_RESET;
      rqs_ff <= 1'b0;
      cmd_ff <= CMD_IDLE;
    end
    else
    begin
      ext_ff <= nxt_ext;
      mask_ff <= nxt_mask;
      rqs_ff <= nxt_rqs;
      cmd_ff <= nxt_cmd;
    end
  end

  // Outputs come straight from flip-flops or flip-flop bits
  // The primary byte only merges flop bits at distinct positions, so no gating
  assign primary_service_status_o = pri_cond | ({7'h00, rqs_ff} << `PRI_RQS_BIT);
  assign extended_condition_status_o = ext_ff;
  assign request_mask_o = mask_ff;
  assign service_request_o = rqs_ff;

  // Assertions: most watch outputs; a few read internal decodes where the
  // rule is about the cause rather than the visible result
  sequence mask_load_s;
    cmd_valid_i && cmd_byte_i == `MASK_LOAD_CODE && cmd_ff == CMD_IDLE && !device_clear_i
    ##1 cmd_valid_i && !device_clear_i;
  endsequence

  mask_load_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    mask_load_s |=> request_mask_o == $past(cmd_byte_i))
    else $error("mask byte not loaded after code");

  rqs_raise_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (mask_hit && !device_clear_i) |=> service_request_o && primary_service_status_o[`PRI_RQS_BIT])
    else $error("masked condition did not raise request");

  rqs_cause_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $rose(service_request_o) |-> $past(mask_hit))
    else $error("request raised without masked condition");

  clear_drop_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    device_clear_i |=> !service_request_o)
    else $error("device clear did not drop request");

  syntax_set_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    syntax_error_i |=> primary_service_status_o[`PRI_SYNTAX_BIT])
    else $error("syntax error bit not set");

  param_set_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    param_altered_i |=> primary_service_status_o[`PRI_PARAM_BIT])
    else $error("parameter altered bit not set");

  sweep_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    primary_service_status_o[`PRI_SWEEP_BIT] && !device_clear_i |=> primary_service_status_o[`PRI_SWEEP_BIT])
    else $error("sweep end bit lost before clear");

  ext_change_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $changed(extended_condition_status_o) && !device_clear_i |=> primary_service_status_o[`PRI_EXTCHG_BIT])
    else $error("extended change not flagged");

  unused_zero_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (primary_service_status_o & `PRI_UNUSED_MASK) == `STATUS_RESET &&
    (extended_condition_status_o & `EXT_UNUSED_MASK) == `STATUS_RESET)
    else $error("unused status bit set");

  // Pins reach the extended byte after two sync stages and the byte flop
  ext_follow_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ##3 extended_condition_status_o[`EXT_AIRFLOW_BIT] == $past(airflow_fail_i, 3))
    else $error("airflow bit does not follow pin");

  ext_unlevel_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ##3 extended_condition_status_o[`EXT_UNLEVEL_BIT] == $past(rf_unleveled_i, 3))
    else $error("unleveled bit does not follow pin");

  ext_power_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ##3 extended_condition_status_o[`EXT_POWER_BIT] == $past(power_event_i, 3))
    else $error("power bit does not follow pin");

  ext_selftest_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ##3 extended_condition_status_o[`EXT_SELFTEST_BIT] == $past(selftest_fail_i, 3))
    else $error("self test bit does not follow pin");

  // End of sweep is latched like the other primary causes
  sweep_set_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    sweep_end_i |=> primary_service_status_o[`PRI_SWEEP_BIT])
    else $error("sweep end bit not set");

  // Once raised, the request stands until the controller clears the device
  rqs_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    service_request_o && !device_clear_i |=> service_request_o)
    else $error("request dropped without device clear");

  // Device clear empties every cause that no new event sets in that cycle
  clear_status_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    device_clear_i && !param_altered_i && !syntax_error_i && !sweep_end_i && !ext_changed
    |=> (primary_service_status_o & `PRI_COND_MASK) == `STATUS_RESET)
    else $error("device clear left a status bit set");

  // Without a command byte the mask cannot move
  mask_keep_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !cmd_valid_i |=> $stable(request_mask_o))
    else $error("mask changed without a command byte");

  // Code accepted, then device clear in the following cycle
  sequence load_cut_s;
    cmd_valid_i && cmd_byte_i == `MASK_LOAD_CODE && cmd_ff == CMD_IDLE && !device_clear_i
    ##1 device_clear_i;
  endsequence

  load_abort_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    load_cut_s |=> $stable(request_mask_o))
    else $error("mask loaded despite device clear");

endmodule
`default_nettype wire

// [status_bus_controller.sv]
/*
  Bus controller model: programs the request mask, waits for a service
  request, reads the primary status and issues device clear.
  Assumes the unit samples its inputs on the rising edge of ref_clk_i.
*/
`default_nettype none
`include "status_service_regs.svh"
module status_bus_controller
(
  // Clock
  input wire logic ref_clk_i,
  // Observed device state
  input wire logic service_request_i,
  input wire logic [7:0] primary_i,
  // Command stream and clear
  output logic cmd_valid_o,
  output logic [7:0] cmd_byte_o,
  output logic device_clear_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    cmd_valid_o = 1'b0;
    cmd_byte_o = 8'h00;
    device_clear_o = 1'b0;
  end
  // One byte, one cycle; the bus lines show the inverse once released
  task automatic send(input logic [7:0] b);
    @(negedge ref_clk_i);
    cmd_valid_o = 1'b1;
    cmd_byte_o = b;
    @(negedge ref_clk_i);
    cmd_valid_o = 1'b0;
    cmd_byte_o = ~b;
  endtask
  // Mask byte meets device clear in one cycle: the load is abandoned
  task automatic cut_load(input logic [7:0] b);
    @(negedge ref_clk_i);
    cmd_valid_o = 1'b1;
    cmd_byte_o = `MASK_LOAD_CODE;
    @(negedge ref_clk_i);
    cmd_byte_o = b;
    device_clear_o = 1'b1;
    @(negedge ref_clk_i);
    cmd_valid_o = 1'b0;
    cmd_byte_o = ~b;
    device_clear_o = 1'b0;
  endtask
  // Device clear wipes the primary status and rearms the request
  task automatic clear_dev;
    @(negedge ref_clk_i);
    device_clear_o = 1'b1;
    @(negedge ref_clk_i);
    device_clear_o = 1'b0;
  endtask
  // Clear first so stale causes raise nothing, then code and mask
  task automatic load_mask(input logic [7:0] m);
    clear_dev;
    send(`MASK_LOAD_CODE);
    send(m);
  endtask
  // Poll the request line within a bounded wait, then read the cause
  task automatic wait_request(output logic got, output logic [7:0] st);
    got = 1'b0;
    for (int i = 0; i < 20 && !got; i++)
    begin
      @(negedge ref_clk_i);
      got = service_request_i;
    end
    st = primary_i;
  endtask
endmodule
`default_nettype wire

// [test_status_service_request_unit.sv]
/*
  Self-checking bench for the status and service-request unit with an
  integer reference model. Assumes inputs change at the falling edge.
*/
`default_nettype none
`include "status_service_regs.svh"
module test_status_service_request_unit;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i, rst_n_i, cmd_valid, clr, p_alt, syn, swp, air, unl, pwr, stf, srq, got;
  logic [7:0] cmd_b, pri, ext, mask, sb, ep;
  int failures, total_checks, cond, mask_m, ext_m;
  int cause_q[$]; // Status weights raised since the last compare
  status_service_request_unit u_status_service_request_unit (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .cmd_valid_i(cmd_valid), .cmd_byte_i(cmd_b), .device_clear_i(clr), .param_altered_i(p_alt),
    .syntax_error_i(syn), .sweep_end_i(swp), .airflow_fail_i(air), .rf_unleveled_i(unl),
    .power_event_i(pwr), .selftest_fail_i(stf), .primary_service_status_o(pri),
    .extended_condition_status_o(ext), .request_mask_o(mask), .service_request_o(srq));
  status_bus_controller u_bus_controller (.ref_clk_i(ref_clk_i), .service_request_i(srq),
    .primary_i(pri), .cmd_valid_o(cmd_valid), .cmd_byte_o(cmd_b), .device_clear_o(clr));
  // 20 MHz clock
  initial
  begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  task automatic results;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e)
    begin
      failures++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // Model: request only from masked latched causes; bit6 not maskable
  task automatic compare_all;
    while (cause_q.size() > 0)
      cond |= cause_q.pop_front();
    ep = 8'(cond);
    ep[6] = |(ep & 8'(mask_m) & `PRI_COND_MASK);
    check(pri, ep);
    check({7'h00, srq}, {7'h00, ep[6]});
    check(ext, 8'(ext_m));
    check(mask, 8'(mask_m));
  endtask
  // Event pulses: param, syntax, sweep
  task automatic pulse(input logic [2:0] ev);
    @(negedge ref_clk_i);
    {p_alt, syn, swp} = ev;
    @(negedge ref_clk_i);
    {p_alt, syn, swp} = 3'b000;
    cause_q.push_back(int'(ev[2]) | (int'(ev[1]) << `PRI_SYNTAX_BIT) | (int'(ev[0]) << `PRI_SWEEP_BIT));
    repeat (3) @(negedge ref_clk_i);
  endtask
  // Pin levels pass a synchroniser, so allow several cycles
  task automatic pins(input logic [3:0] v);
    @(negedge ref_clk_i);
    {air, unl, pwr, stf} = v;
    if ({v[3:1], 4'h0, v[0]} != ext_m)
      cause_q.push_back(1 << `PRI_EXTCHG_BIT);
    ext_m = {v[3:1], 4'h0, v[0]};
    repeat (7) @(negedge ref_clk_i);
  endtask
  task automatic do_clear;
    u_bus_controller.clear_dev();
    cond = 0;
    cause_q.delete();
    repeat (2) @(negedge ref_clk_i);
  endtask
  initial
  begin
    rst_n_i = 1'b0;
    {p_alt, syn, swp, air, unl, pwr, stf} = 7'h00;
    void'($urandom(32'h8d43));
    repeat (3) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    compare_all();
    $display("test reset done");
    u_bus_controller.send(8'h12);
    u_bus_controller.load_mask(8'd97);
    mask_m = 97;
    repeat (2) @(negedge ref_clk_i);
    compare_all();
    pulse(3'b100);
    u_bus_controller.wait_request(got, sb);
    check({7'h00, got}, 8'h01);
    check(sb, 8'h41);
    do_clear();
    compare_all();
    pulse(3'b001);
    compare_all();
    pulse(3'b010);
    compare_all();
    // Mask byte meeting device clear is dropped, and so is a lone byte after it
    u_bus_controller.cut_load(8'h12);
    u_bus_controller.send(8'h34);
    cond = 0;
    repeat (2) @(negedge ref_clk_i);
    compare_all();
    $display("test mask done");
    // Random masks, causes and pin levels; latching holds until clear
    for (int i = 0; i < 10; i++)
    begin
      mask_m = $urandom & 8'hff;
      u_bus_controller.load_mask(8'(mask_m));
      cond = 0;
      repeat (2) @(negedge ref_clk_i);
      pulse(3'($urandom));
      pins(4'($urandom));
      compare_all();
      pulse(3'b000);
      compare_all();
      do_clear();
      compare_all();
    end
    $display("test random done");
    // Reset in mid-run with pins idle: all outputs and the mask return to zero
    @(negedge ref_clk_i);
    rst_n_i = 1'b0;
    {air, unl, pwr, stf} = 4'h0;
    repeat (3) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    cond = 0;
    mask_m = 0;
    ext_m = 0;
    repeat (2) @(negedge ref_clk_i);
    compare_all();
    $display("test reset again done");
    results();
  end
  // Watchdog well beyond the expected run
  initial
  begin
    #(4000 * 50);
    failures++;
    results();
  end
endmodule
`default_nettype wire
